// ### low_power_wakeup_control.sv
`default_nettype none
module low_power_wakeup_control #(
  parameter int WAKE_PLL = lpw_pkg::WAKE_CYCLES_PLL,
  parameter int WAKE_1TO1 = lpw_pkg::WAKE_CYCLES_1TO1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire lpw_pkg::wake_src_s wake_src,
  input wire logic hard_reset_in,
  output logic timer_expiry_pin,
  output logic pll_enable,
  output logic core_run,
  output logic clk_gear_low,
  output logic irq
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [5:0] sync_q;
  lpw_sync #(.WIDTH(6)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .d({hard_reset_in, wake_src}),
    .q(sync_q)
  );
  wire hard_reset_in_s = sync_q[5];
  wire ctrl_irq_s = sync_q[4];
  wire timer_evt = |sync_q[3:0];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl;
  logic [1:0] status;
  logic [1:0] mask;
  logic hard_reset_in_d;
  logic [9:0] wake_cnt;
  lpw_pkg::pmode_e state;
  lpw_pkg::pmode_e next_state;

  wire wr_ctrl = wr && addr == lpw_pkg::ADDR_CTRL;
  wire wr_status = wr && addr == lpw_pkg::ADDR_STATUS;
  wire wr_mask = wr && addr == lpw_pkg::ADDR_MASK;
  wire timer_expiry_pin_en = ctrl[lpw_pkg::CTRL_TIMER_EXPIRY_PIN_EN_BIT];
  wire pow_en = ctrl[lpw_pkg::CTRL_POW_BIT];
  wire one2one = ctrl[lpw_pkg::CTRL_ONE2ONE_BIT];
  wire timer_expiry_status = status[lpw_pkg::ST_TIMER_EXPIRY_PIN_BIT];
  wire hard_reset_in_rise = hard_reset_in_s && !hard_reset_in_d;
  wire timer_set = timer_expiry_pin_en && timer_evt;
  wire timer_expiry_pin_set = timer_set || (hard_reset_in_rise && !timer_expiry_status);
  wire timer_expiry_pin_clr = wr_status && wdata[lpw_pkg::ST_TIMER_EXPIRY_PIN_BIT];
  wire wake_set = ctrl_irq_s || timer_set;
  wire wake_clr = wr_status && wdata[lpw_pkg::ST_WAKE_BIT];
  // A set timer expiry status bit counts as a pending wake condition until cleared
  wire wake_pending = ctrl_irq_s || timer_set || timer_expiry_status;
  wire is_normal = state == lpw_pkg::ST_NORMAL_HIGH || state == lpw_pkg::ST_NORMAL_LOW;
  wire mode_req = wr_ctrl && pow_en && is_normal;
  wire [1:0] req_mode = wdata[lpw_pkg::CTRL_MODE_LSB +: 2];
  wire [9:0] wake_limit = one2one ? 10'(WAKE_1TO1) : 10'(WAKE_PLL);
  wire wake_done = wake_cnt >= wake_limit - 10'h001;
  // Both status bits are gated by mask
  wire next_irq = |(status & mask);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= lpw_pkg::CTRL_RESET;
      mask <= lpw_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        // Mode bits cannot be changed outside a normal mode
        ctrl <= is_normal ? wdata : {wdata[7:2], ctrl[1:0]};
      end else if (state == lpw_pkg::ST_NORMAL_HIGH && wake_pending) begin
        ctrl[lpw_pkg::CTRL_MODE_LSB +: 2] <= lpw_pkg::MODE_NORMAL;
      end
      if (wr_mask) begin
        mask <= wdata[1:0];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
      hard_reset_in_d <= 1'b0;
    end else begin
      hard_reset_in_d <= hard_reset_in_s;
      status[lpw_pkg::ST_TIMER_EXPIRY_PIN_BIT] <= timer_expiry_pin_set || (timer_expiry_status && !timer_expiry_pin_clr);
      status[lpw_pkg::ST_WAKE_BIT] <= wake_set || (status[lpw_pkg::ST_WAKE_BIT] && !wake_clr);
    end
  end

  // ----------------------------------------
  // Power mode sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      lpw_pkg::ST_NORMAL_HIGH: begin
        if (mode_req && req_mode == lpw_pkg::MODE_DEEP) begin
          next_state = timer_expiry_status ? lpw_pkg::ST_DEEP_SLEEP : lpw_pkg::ST_POWER_DOWN;
        end else if (mode_req && req_mode == lpw_pkg::MODE_SLEEP) begin
          next_state = lpw_pkg::ST_SLEEP;
        end else if (mode_req && req_mode == lpw_pkg::MODE_DOZE) begin
          next_state = lpw_pkg::ST_DOZE;
        end else if (ctrl[lpw_pkg::CTRL_GEAR_BIT] && pow_en && !wake_pending) begin
          next_state = lpw_pkg::ST_NORMAL_LOW;
        end
      end
      lpw_pkg::ST_NORMAL_LOW: begin
        if (mode_req && req_mode == lpw_pkg::MODE_DEEP) begin
          next_state = timer_expiry_status ? lpw_pkg::ST_DEEP_SLEEP : lpw_pkg::ST_POWER_DOWN;
        end else if (mode_req && req_mode == lpw_pkg::MODE_SLEEP) begin
          next_state = lpw_pkg::ST_SLEEP;
        end else if (mode_req && req_mode == lpw_pkg::MODE_DOZE) begin
          next_state = lpw_pkg::ST_DOZE;
        end else if (ctrl_irq_s || !pow_en || !ctrl[lpw_pkg::CTRL_GEAR_BIT]) begin
          next_state = lpw_pkg::ST_NORMAL_HIGH;
        end
      end
      lpw_pkg::ST_DOZE, lpw_pkg::ST_SLEEP: begin
        if (wake_pending) begin
          next_state = lpw_pkg::ST_NORMAL_HIGH;
        end
      end
      lpw_pkg::ST_DEEP_SLEEP: begin
        // PLL relock period counted by wake_cnt before leaving
        if (wake_done && wake_cnt != 10'h000) begin
          next_state = lpw_pkg::ST_NORMAL_HIGH;
        end
      end
      lpw_pkg::ST_POWER_DOWN: begin
        if (hard_reset_in_rise) begin
          next_state = lpw_pkg::ST_NORMAL_HIGH;
        end
      end
      default: next_state = lpw_pkg::ST_NORMAL_HIGH;
    endcase
  end

  // Wake counter runs only after a wake event in deep-sleep
  logic waking;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waking <= 1'b0;
      wake_cnt <= '0;
    end else if (state != lpw_pkg::ST_DEEP_SLEEP) begin
      waking <= 1'b0;
      wake_cnt <= '0;
    end else if (waking || (wake_pending && (ctrl_irq_s || timer_evt))) begin
      waking <= 1'b1;
      wake_cnt <= wake_cnt + 10'h001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= lpw_pkg::ST_NORMAL_HIGH;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  wire next_pll = !((next_state == lpw_pkg::ST_DEEP_SLEEP && !waking && !(ctrl_irq_s || timer_evt))
                    || next_state == lpw_pkg::ST_POWER_DOWN);
  wire next_run = next_state == lpw_pkg::ST_NORMAL_HIGH || next_state == lpw_pkg::ST_NORMAL_LOW;
  wire next_pin = timer_expiry_pin_set || (timer_expiry_pin && !timer_expiry_pin_clr);
  logic [7:0] next_rdata;
  always_comb begin
    case (addr)
      lpw_pkg::ADDR_CTRL: next_rdata = ctrl;
      lpw_pkg::ADDR_STATUS: next_rdata = {6'h00, status};
      lpw_pkg::ADDR_MASK: next_rdata = {6'h00, mask};
      lpw_pkg::ADDR_STATE: next_rdata = {2'h0, state};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      timer_expiry_pin <= 1'b0;
      pll_enable <= 1'b1;
      core_run <= 1'b1;
      clk_gear_low <= 1'b0;
      irq <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
      timer_expiry_pin <= next_pin;
      pll_enable <= next_pll;
      core_run <= next_run;
      clk_gear_low <= next_state == lpw_pkg::ST_NORMAL_LOW;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

// ### low_power_wakeup_control_test.sv
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module low_power_wakeup_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Bench
  // ----
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic kick = 1'b0;
  lpw_pkg::wake_src_s wake_src = '0;
  logic [7:0] rdata;
  logic hard_reset_in, timer_expiry_pin, pll_enable, core_run, clk_gear_low, irq;
  int n_errors = 0;
  int n_tests = 0;
  always #25 core_clk = ~core_clk;
  // Short wake counts keep the run brief; they differ so a mode mix-up shows
  low_power_wakeup_control #(.WAKE_PLL(40), .WAKE_1TO1(8)) dut_u (.core_clk, .nrst, .addr, .wdata, .wr, .rd,
    .rdata, .wake_src, .hard_reset_in, .timer_expiry_pin, .pll_enable, .core_run, .clk_gear_low, .irq);
  lpw_supply_model sup_u (.core_clk, .nrst, .timer_expiry_pin, .pll_enable, .kick, .hard_reset_in);
  task results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task chk_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task wait_run(input int lim);
    int n;
    n = 0;
    while (core_run !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > lim) begin
        n_errors++;
        results();
      end
    end
  endtask
  task t_reset;
    chk_reg(lpw_pkg::ADDR_CTRL, lpw_pkg::CTRL_RESET);
    chk_reg(lpw_pkg::ADDR_MASK, 8'h00);
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_NORMAL_HIGH));
    chk_reg(4'h2, 8'h00);
    $display("t_reset done");
  endtask
  task t_deep(input logic [7:0] c, input int lim);
    wr_reg(lpw_pkg::ADDR_CTRL, 8'h28);
    wr_reg(lpw_pkg::ADDR_MASK, 8'h01);
    @(posedge core_clk) wake_src <= 5'h01;
    repeat (2) @(posedge core_clk);
    wake_src <= '0;
    repeat (6) @(posedge core_clk);
    `CHK("pin", 1'b1, timer_expiry_pin)
    `CHK("irq", 1'b1, irq)
    wr_reg(lpw_pkg::ADDR_CTRL, c);
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_DEEP_SLEEP));
    `CHK("pll", 1'b0, pll_enable)
    `CHK("run", 1'b0, core_run)
    @(posedge core_clk) wake_src <= 5'h10;
    wait_run(lim);
    wake_src <= '0;
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_NORMAL_HIGH));
    wr_reg(lpw_pkg::ADDR_STATUS, 8'h02);
    chk_reg(lpw_pkg::ADDR_STATUS, 8'h01);
    wr_reg(lpw_pkg::ADDR_STATUS, 8'h01);
    chk_reg(lpw_pkg::ADDR_STATUS, 8'h00);
    `CHK("pin", 1'b0, timer_expiry_pin)
    `CHK("irq", 1'b0, irq)
    $display("t_deep done");
  endtask
  task t_pd;
    wr_reg(lpw_pkg::ADDR_CTRL, 8'h2b);
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_POWER_DOWN));
    @(posedge core_clk) wake_src <= 5'h10;
    repeat (8) @(posedge core_clk);
    wake_src <= '0;
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_POWER_DOWN));
    @(posedge core_clk) wake_src <= 5'h08;
    wait_run(80);
    wake_src <= '0;
    // Let the synchroniser drain so the wake event no longer re-sets the status
    repeat (2) @(posedge core_clk);
    wr_reg(lpw_pkg::ADDR_STATUS, 8'h02);
    chk_reg(lpw_pkg::ADDR_STATUS, 8'h01);
    wr_reg(lpw_pkg::ADDR_STATUS, 8'h01);
    wr_reg(lpw_pkg::ADDR_CTRL, 8'h2b);
    @(posedge core_clk) kick <= 1'b1;
    @(posedge core_clk) kick <= 1'b0;
    wait_run(80);
    `CHK("pin", 1'b1, timer_expiry_pin)
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_NORMAL_HIGH));
    $display("t_pd done");
  endtask
  task t_gear;
    wr_reg(lpw_pkg::ADDR_CTRL, 8'h2c);
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_NORMAL_HIGH));
    wr_reg(lpw_pkg::ADDR_STATUS, 8'h03);
    chk_reg(lpw_pkg::ADDR_STATE, 8'(lpw_pkg::ST_NORMAL_LOW));
    `CHK("gear", 1'b1, clk_gear_low)
    `CHK("run", 1'b1, core_run)
    $display("t_gear done");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_deep(8'h2b, 46);
    t_deep(8'h3b, 14);
    t_pd();
    t_gear();
    results();
  end
endmodule
`default_nettype wire

// ### lpw_pkg.sv
`default_nettype none
// Overview of operation
// - Deep-sleep returns to normal-high on controller interrupt, timer interrupt or decrementer exception
// - PLL stays disabled during deep-sleep and restarts only on wake-up
// - Deep-sleep wake-up completes within 500 PLL input clocks in normal PLL mode
// - In one-to-one PLL mode deep-sleep wake-up completes within 100 input clocks
// - Power-down is left only by hard reset, never by an interrupt
// - Any enabled timer or decrementer interrupt sets the timer expiry status
// - Hard reset with status clear sets status, drives pin, exits power-down
// - Status clears only on a software write of one; zero writes do nothing
// - Enabled alarm matches or counts reaching zero drive the expiry pin
// - Writing one to the status negates the expiry pin
// - Core runs only in normal-high and normal-low; halted in every other mode
// - Normal-high to normal-low only when no asynchronous wake condition is pending
// - Mode 11 enters deep-sleep if status set, else power-down; only from enabled normal
package lpw_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'hC;
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GEAR_BIT = 2;
  localparam int CTRL_POW_BIT = 3;
  localparam int CTRL_ONE2ONE_BIT = 4;
  localparam int CTRL_TIMER_EXPIRY_PIN_EN_BIT = 5;
  // Status and mask fields
  localparam int ST_TIMER_EXPIRY_PIN_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_BITS = 2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DOZE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_DEEP = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int WAKE_CYCLES_PLL = 500;
  localparam int WAKE_CYCLES_1TO1 = 100;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_NORMAL_HIGH = 6'b00_0001,
    ST_NORMAL_LOW = 6'b00_0010,
    ST_DOZE = 6'b00_0100,
    ST_SLEEP = 6'b00_1000,
    ST_DEEP_SLEEP = 6'b01_0000,
    ST_POWER_DOWN = 6'b10_0000
  } pmode_e;
  typedef struct packed {
    logic ctrl_irq;
    logic rtc_match;
    logic tb_match;
    logic pit_zero;
    logic dec_zero;
  } wake_src_s;
endpackage
`default_nettype wire

// ### lpw_props.sv
`default_nettype none
// ----
// Port checker
// ----
module lpw_props #(
  parameter int WAKE_PLL = 500,
  parameter int WAKE_1TO1 = 100
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire lpw_pkg::wake_src_s wake_src,
  input wire logic hard_reset_in,
  input wire logic timer_expiry_pin,
  input wire logic pll_enable,
  input wire logic core_run,
  input wire logic irq
);
  localparam int B_PLL = WAKE_PLL + 6;
  localparam int B_ONE = WAKE_1TO1 + 6;
  logic [3:0] hr_sh;
  logic [3:0] ev_sh;
  logic o2o;
  logic en_m;
  logic [1:0] mask_m;
  wire ctrl_wr = wr && addr == lpw_pkg::ADDR_CTRL;
  // Mirrors of written fields, since the checker cannot see registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hr_sh <= 4'h0;
      ev_sh <= 4'h0;
      o2o <= 1'b0;
      en_m <= 1'b0;
      mask_m <= 2'h0;
    end else begin
      hr_sh <= {hr_sh[2:0], hard_reset_in};
      ev_sh <= {ev_sh[2:0], (|wake_src) | hard_reset_in};
      if (ctrl_wr) begin
        o2o <= wdata[lpw_pkg::CTRL_ONE2ONE_BIT];
        en_m <= wdata[lpw_pkg::CTRL_TIMER_EXPIRY_PIN_EN_BIT];
      end
      if (wr && addr == lpw_pkg::ADDR_MASK) begin
        mask_m <= wdata[1:0];
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence pd_now;
    !pll_enable && !timer_expiry_pin && en_m;
  endsequence
  sequence woke;
    $rose(pll_enable) && hr_sh == 4'h0;
  endsequence
  a_pin_clear: assert property (wr && addr == lpw_pkg::ADDR_STATUS && wdata[0] && ev_sh == 4'h0
    |-> ##[1:2] !timer_expiry_pin) else $error("pin high after clear");
  a_core_halt: assert property (!pll_enable |-> !core_run) else $error("core runs with pll off");
  a_pll_wake: assert property (woke |-> !core_run) else $error("pll late on wake");
  a_wake_time: assert property (woke ##0 !o2o |-> ##[1:B_PLL] core_run)
    else $error("slow wake");
  a_wake_fast: assert property (woke ##0 o2o |-> ##[1:B_ONE] core_run)
    else $error("slow fast wake");
  a_hard_reset_in_pin: assert property (pd_now ##0 $rose(hard_reset_in) |-> ##[1:4] timer_expiry_pin)
    else $error("no pin on hard reset");
  a_pd_hold: assert property (pd_now ##0 hr_sh == 4'h0 && !hard_reset_in |=> !pll_enable)
    else $error("left power-down early");
  a_irq_mask: assert property (mask_m == 2'h0 && $past(mask_m) == 2'h0 |-> !irq)
    else $error("irq while masked");
endmodule
bind low_power_wakeup_control lpw_props #(.WAKE_PLL(WAKE_PLL), .WAKE_1TO1(WAKE_1TO1)) props_u (.core_clk, .nrst,
  .addr, .wdata, .wr, .wake_src, .hard_reset_in, .timer_expiry_pin, .pll_enable, .core_run, .irq);
`default_nettype wire

// ### lpw_supply_model.sv
`default_nettype none
// ----
// Supply switch and hard reset source
// ----
module lpw_supply_model #(
  parameter int HOLD = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic timer_expiry_pin,
  input wire logic pll_enable,
  input wire logic kick,
  output logic hard_reset_in
);
  logic pin_d;
  logic [3:0] cnt;
  // Reacts to a pin edge only while the clock unit is off, and to kick at any time; a pin edge in normal mode is ignored
  wire go = kick || (timer_expiry_pin && !pin_d && !pll_enable);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_d <= 1'b0;
      cnt <= 4'h0;
    end else begin
      pin_d <= timer_expiry_pin;
      if (go && cnt == 4'h0) begin
        cnt <= 4'(HOLD);
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  assign hard_reset_in = cnt != 4'h0;
endmodule
`default_nettype wire

// ### lpw_sync.sv
`default_nettype none
module lpw_sync #(
  parameter int WIDTH = 6
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // First stage is read only by the second stage
  logic [WIDTH-1:0] meta;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire
